// File: core/port_data_pkg.sv
// Constants and types shared by the port data register block
package port_data_pkg;
   localparam int NUM_PORTS = 11;
   localparam int BYTE_W = 8;
   typedef logic [NUM_PORTS-1:0][BYTE_W-1:0] port_vec_t;
   typedef logic [15:0] addr_table_t [NUM_PORTS];
   typedef logic [BYTE_W-1:0] byte_table_t [NUM_PORTS];
   // Data register offsets, ports 0-7, 12, 13, 14
   localparam addr_table_t DATA_OFFSET = '{16'hff00, 16'hff01, 16'hff02, 16'hff03, 16'hff04, 16'hff05,
      16'hff06, 16'hff07, 16'hff0c, 16'hff0d, 16'hff0e};
   // Direction register offsets; port 13 is output only and has none
   localparam addr_table_t DIR_OFFSET = '{16'hff20, 16'hff21, 16'hff22, 16'hff23, 16'hff24, 16'hff25,
      16'hff26, 16'hff27, 16'hff2c, 16'h0000, 16'hff2e};
   localparam logic [NUM_PORTS-1:0] HAS_DIR = 11'h5ff;
   // Implemented pin positions per port
   localparam byte_table_t PIN_MASK = '{8'h7f, 8'hff, 8'hff, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'hff,
      8'h1f, 8'h01, 8'h03};
   // Pins shared with the oscillators, only on port 12
   localparam byte_table_t MAIN_CLK_PINS = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h06, 8'h00, 8'h00};
   localparam byte_table_t SUB_CLK_PINS = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h18, 8'h00, 8'h00};
   localparam logic [BYTE_W-1:0] DATA_RESET = 8'h00;
   localparam logic [BYTE_W-1:0] DIR_RESET = 8'hff;
   localparam logic [BYTE_W-1:0] DIR_FIXED_OUT = 8'h00;
   localparam logic [BYTE_W-1:0] OE_RESET = 8'h00;
   localparam logic [BYTE_W-1:0] CLK_ZERO_RESET = 8'h00;
   localparam logic CLK_MODE_RESET = 1'b0;
   localparam logic [BYTE_W-1:0] READ_IDLE = 8'h00;
   // Clock pin mode register and single-bit alias window
   localparam logic [15:0] CLK_MODE_OFFSET = 16'hff40;
   localparam int CLK_MODE_MAIN_BIT = 0;
   localparam int CLK_MODE_SUB_BIT = 1;
   localparam logic [15:0] BIT_BASE = 16'hf800;
   localparam int BIT_BASE_LSB = 7;
   localparam int BIT_IDX_LSB = 3;
   localparam int IDX_W = 4;
   localparam int BIT_SEL_W = 3;
endpackage

// File: core/port_bus_if.sv
// Write path and latch contents between register decode and latch bank
`timescale 1ns/1ps
`default_nettype none
interface port_bus_if;
   logic byte_wr;
   logic bit_wr;
   logic [port_data_pkg::IDX_W-1:0] idx;
   logic [port_data_pkg::BIT_SEL_W-1:0] bit_sel;
   logic [port_data_pkg::BYTE_W-1:0] data;
   port_data_pkg::port_vec_t latch;
   modport ctrl (output byte_wr, output bit_wr, output idx, output bit_sel, output data, input latch);
   modport bank (input byte_wr, input bit_wr, input idx, input bit_sel, input data, output latch);
endinterface
`default_nettype wire

// File: core/port_latch_bank.sv
// Output latches of all ports
`timescale 1ns/1ps
`default_nettype none
module port_latch_bank
(
   input wire logic clk,
   input wire logic sys_rst,
   port_bus_if.bank bus
);
   port_data_pkg::port_vec_t latch;
   port_data_pkg::port_vec_t next_latch;

   genvar p;
   generate
      for (p = 0; p < port_data_pkg::NUM_PORTS; p++)
      begin : g_port
         always_comb
         begin
            next_latch[p] = latch[p];
            if (bus.byte_wr && bus.idx == port_data_pkg::IDX_W'(p))
            begin
               next_latch[p] = bus.data & port_data_pkg::PIN_MASK[p];
            end
            else if (bus.bit_wr && bus.idx == port_data_pkg::IDX_W'(p))
            begin
               next_latch[p][bus.bit_sel] = bus.data[0] & port_data_pkg::PIN_MASK[p][bus.bit_sel];
            end
         end

         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               latch[p] <= port_data_pkg::DATA_RESET;
            end
            else
            begin
               latch[p] <= next_latch[p];
            end
         end
      end
   endgenerate

   assign bus.latch = latch;
endmodule
`default_nettype wire

// File: core/port_data_registers.sv
// Port data registers with direction, clock pin mode and read path
//
// Summary of operation
// - A write stores the value in the port latch, which drives output pins.
// - Reading an input-mode bit returns the present pin level.
// - Reading an output-mode bit returns the latch value.
// - Port latches take whole-byte writes and single-bit writes without disturbing others.
// - Reset clears every output latch to zero.
// - Latch 0 drives low, 1 drives high; read 0 means low pin, 1 high.
// - Oscillator-shared port bits read zero while in external clock input mode.
// - Direction bit 0 enables the output buffer, 1 makes the pin an input.
// - A latch keeps its value until rewritten; reads never change it.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module port_data_registers
#(
   parameter int NUM_PORTS = port_data_pkg::NUM_PORTS
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output var logic [7:0] rd_data,
   input wire logic [NUM_PORTS-1:0][7:0] pin_in,
   output var logic [NUM_PORTS-1:0][7:0] pin_out,
   output var logic [NUM_PORTS-1:0][7:0] pin_oe
);
   if (NUM_PORTS != port_data_pkg::NUM_PORTS)
   begin : g_bad_ports
      $error("NUM_PORTS must match the port map");
   end

   // The decode result holds a port index below its hit flag
   if ((1 << port_data_pkg::IDX_W) < NUM_PORTS)
   begin : g_bad_idx_w
      $error("IDX_W is too narrow for the port count");
   end

   // Pin and data ports are declared one byte wide
   if (port_data_pkg::BYTE_W != 8)
   begin : g_bad_byte_w
      $error("BYTE_W must be 8");
   end

   if ((1 << port_data_pkg::BIT_SEL_W) != port_data_pkg::BYTE_W)
   begin : g_bad_sel_w
      $error("BIT_SEL_W must address every bit of a byte");
   end

   // Alias address: bit select at the bottom, port index above it, window base on top
   if (port_data_pkg::BIT_IDX_LSB != port_data_pkg::BIT_SEL_W)
   begin : g_bad_idx_lsb
      $error("BIT_IDX_LSB must equal BIT_SEL_W");
   end

   if (port_data_pkg::BIT_BASE_LSB - port_data_pkg::BIT_IDX_LSB != port_data_pkg::IDX_W)
   begin : g_bad_base_lsb
      $error("alias window must hold exactly IDX_W index bits");
   end

   if (port_data_pkg::BIT_BASE[port_data_pkg::BIT_BASE_LSB-1:0] != '0)
   begin : g_bad_base
      $error("alias window base must be aligned to the window");
   end

   if (port_data_pkg::CLK_MODE_MAIN_BIT >= port_data_pkg::BYTE_W
      || port_data_pkg::CLK_MODE_SUB_BIT >= port_data_pkg::BYTE_W
      || port_data_pkg::CLK_MODE_MAIN_BIT == port_data_pkg::CLK_MODE_SUB_BIT)
   begin : g_bad_clk_bits
      $error("clock mode bits must be distinct bits of one byte");
   end

   // Each oscillator pin must exist on its port and serve one oscillator only
   for (genvar c = 0; c < port_data_pkg::NUM_PORTS; c++)
   begin : g_chk_clk_pins
      if (((port_data_pkg::MAIN_CLK_PINS[c] | port_data_pkg::SUB_CLK_PINS[c]) & ~port_data_pkg::PIN_MASK[c]) != '0)
      begin : g_bad_clk_pins
         $error("oscillator pin outside the implemented pins");
      end
      if ((port_data_pkg::MAIN_CLK_PINS[c] & port_data_pkg::SUB_CLK_PINS[c]) != '0)
      begin : g_shared_clk_pins
         $error("a pin cannot serve both oscillators");
      end
   end

   // Returns hit flag above the port index of a matching table entry
   function automatic logic [port_data_pkg::IDX_W:0] find_port(
      input logic [15:0] a,
      input port_data_pkg::addr_table_t table_in,
      input logic [NUM_PORTS-1:0] valid);
      logic [port_data_pkg::IDX_W:0] res;
      res = '0;
      for (int i = 0; i < NUM_PORTS; i++)
      begin
         if (valid[i] && a == table_in[i])
         begin
            res = {1'b1, port_data_pkg::IDX_W'(i)};
         end
      end
      return res;
   endfunction

   // Pins handed to an oscillator while it takes an external clock
   function automatic logic [7:0] clk_pin_mask(
      input logic main_ext,
      input logic sub_ext,
      input int port_index);
      logic [7:0] m;
      m = '0;
      if (main_ext)
      begin
         m = m | port_data_pkg::MAIN_CLK_PINS[port_index];
      end
      if (sub_ext)
      begin
         m = m | port_data_pkg::SUB_CLK_PINS[port_index];
      end
      return m;
   endfunction

   // Per bit: input pins show their level, output pins their latch; masked bits read zero
   function automatic logic [7:0] pin_view(
      input logic [7:0] mask,
      input logic [7:0] zero,
      input logic [7:0] dir_bits,
      input logic [7:0] level,
      input logic [7:0] held);
      return mask & ~zero & ((dir_bits & level) | (~dir_bits & held));
   endfunction

   port_bus_if bus ();

   port_latch_bank u_bank
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .bus(bus)
   );

   port_data_pkg::port_vec_t dir;
   port_data_pkg::port_vec_t next_dir;
   port_data_pkg::port_vec_t oe;
   port_data_pkg::port_vec_t next_oe;
   port_data_pkg::port_vec_t clk_zero;
   port_data_pkg::port_vec_t next_clk_zero;
   port_data_pkg::port_vec_t view;
   logic main_external_clock_in;
   logic sub_external_clock_in;
   logic next_main_ext;
   logic next_sub_ext;
   logic [7:0] next_rd_data;
   logic [port_data_pkg::IDX_W:0] data_hit;
   logic [port_data_pkg::IDX_W:0] dir_hit;
   logic bit_hit;
   logic clk_hit;
   logic [port_data_pkg::IDX_W-1:0] bit_idx;
   logic [port_data_pkg::BIT_SEL_W-1:0] bit_sel;
   logic [7:0] view_byte;
   logic [7:0] clk_mode_view;

   // Address decode, shared by read and write paths
   always_comb
   begin
      data_hit = find_port(addr, port_data_pkg::DATA_OFFSET, {NUM_PORTS{1'b1}});
      dir_hit = find_port(addr, port_data_pkg::DIR_OFFSET, port_data_pkg::HAS_DIR);
      bit_idx = addr[port_data_pkg::BIT_BASE_LSB-1:port_data_pkg::BIT_IDX_LSB];
      bit_sel = addr[port_data_pkg::BIT_IDX_LSB-1:0];
      bit_hit = (addr[15:port_data_pkg::BIT_BASE_LSB] == port_data_pkg::BIT_BASE[15:port_data_pkg::BIT_BASE_LSB])
         && (bit_idx < port_data_pkg::IDX_W'(NUM_PORTS));
      clk_hit = (addr == port_data_pkg::CLK_MODE_OFFSET);
   end

   // Byte map and alias window never overlap, so a byte hit may own the index
   // write request to the latch bank
   always_comb
   begin
      bus.byte_wr = wr_en && data_hit[port_data_pkg::IDX_W];
      bus.bit_wr = wr_en && bit_hit;
      bus.idx = data_hit[port_data_pkg::IDX_W] ? data_hit[port_data_pkg::IDX_W-1:0] : bit_idx;
      bus.bit_sel = bit_sel;
      bus.data = wr_data;
   end

   // Clock pin mode register
   always_comb
   begin
      next_main_ext = main_external_clock_in;
      next_sub_ext = sub_external_clock_in;
      if (wr_en && clk_hit)
      begin
         next_main_ext = wr_data[port_data_pkg::CLK_MODE_MAIN_BIT];
         next_sub_ext = wr_data[port_data_pkg::CLK_MODE_SUB_BIT];
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         main_external_clock_in <= port_data_pkg::CLK_MODE_RESET;
         sub_external_clock_in <= port_data_pkg::CLK_MODE_RESET;
      end
      else
      begin
         main_external_clock_in <= next_main_ext;
         sub_external_clock_in <= next_sub_ext;
      end
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++)
      begin : g_port
         always_comb
         begin
            next_dir[p] = dir[p];
            if (wr_en && dir_hit[port_data_pkg::IDX_W] && dir_hit[port_data_pkg::IDX_W-1:0] == port_data_pkg::IDX_W'(p))
            begin
               // Unimplemented direction bits stay as input so they never drive
               next_dir[p] = wr_data | ~port_data_pkg::PIN_MASK[p];
            end
            next_clk_zero[p] = clk_pin_mask(next_main_ext, next_sub_ext, p);
            // buffer on for direction 0
            // Oscillator pins never drive while clocked externally
            next_oe[p] = ~next_dir[p] & port_data_pkg::PIN_MASK[p] & ~next_clk_zero[p];
         end

         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               dir[p] <= port_data_pkg::HAS_DIR[p] ? port_data_pkg::DIR_RESET : port_data_pkg::DIR_FIXED_OUT;
               oe[p] <= port_data_pkg::HAS_DIR[p] ? port_data_pkg::OE_RESET : port_data_pkg::PIN_MASK[p];
               clk_zero[p] <= port_data_pkg::CLK_ZERO_RESET;
            end
            else
            begin
               dir[p] <= next_dir[p];
               oe[p] <= next_oe[p];
               clk_zero[p] <= next_clk_zero[p];
            end
         end

         // level maps straight to bit value
         assign view[p] = pin_view(port_data_pkg::PIN_MASK[p], clk_zero[p], dir[p], pin_in[p], bus.latch[p]);
      end
   endgenerate

   // Read mux; reads have no side effect on any state
   // reads leave latches alone
   always_comb
   begin
      // Alias indexes past the last port have no view; keep the select in range
      view_byte = port_data_pkg::READ_IDLE;
      if (bit_idx < port_data_pkg::IDX_W'(NUM_PORTS))
      begin
         view_byte = view[bit_idx];
      end
      clk_mode_view = port_data_pkg::READ_IDLE;
      clk_mode_view[port_data_pkg::CLK_MODE_MAIN_BIT] = main_external_clock_in;
      clk_mode_view[port_data_pkg::CLK_MODE_SUB_BIT] = sub_external_clock_in;
      next_rd_data = port_data_pkg::READ_IDLE;
      if (rd_en)
      begin
         if (data_hit[port_data_pkg::IDX_W])
         begin
            next_rd_data = view[data_hit[port_data_pkg::IDX_W-1:0]];
         end
         else if (dir_hit[port_data_pkg::IDX_W])
         begin
            next_rd_data = dir[dir_hit[port_data_pkg::IDX_W-1:0]];
         end
         else if (bit_hit)
         begin
            next_rd_data = {7'h00, view_byte[bit_sel]};
         end
         else if (clk_hit)
         begin
            next_rd_data = clk_mode_view;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_data <= port_data_pkg::READ_IDLE;
      end
      else
      begin
         rd_data <= next_rd_data;
      end
   end

   assign pin_out = bus.latch;
   assign pin_oe = oe;
endmodule
`default_nettype wire

// File: verif/port_data_properties.sv
// Port-level checker for the port data register block
`timescale 1ns/1ps
`default_nettype none
module port_data_properties
#(
   parameter int NUM_PORTS = port_data_pkg::NUM_PORTS
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] rd_data,
   input wire logic [NUM_PORTS-1:0][7:0] pin_in,
   input wire logic [NUM_PORTS-1:0][7:0] pin_out,
   input wire logic [NUM_PORTS-1:0][7:0] pin_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_wr_byte; wr_en && addr == 16'hff01 |=> pin_out[1] == $past(wr_data); endproperty
   a_wr_byte: assert property (p_wr_byte) else $error("byte write not stored");
   property p_rd_in; rd_en && addr == 16'hff01 && pin_oe[1] == 8'h00 |=> rd_data == $past(pin_in[1]); endproperty
   a_rd_in: assert property (p_rd_in) else $error("input read not pin level");
   property p_rd_out; rd_en && addr == 16'hff01 && pin_oe[1] == 8'hff |=> rd_data == pin_out[1]; endproperty
   a_rd_out: assert property (p_rd_out) else $error("output read not latch");
   sequence s_bit_wr; wr_en && addr == 16'hf80f; endsequence
   property p_bit; s_bit_wr |=> pin_out[1][7] == $past(wr_data[0]) && pin_out[1][6:0] == $past(pin_out[1][6:0]); endproperty
   a_bit: assert property (p_bit) else $error("bit write disturbed byte");
   property p_rst; $fell(sys_rst) |-> pin_out == '0 && rd_data == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("latch not clear after reset");
   property p_dir; wr_en && addr == 16'hff21 |=> pin_oe[1] == ~$past(wr_data); endproperty
   a_dir: assert property (p_dir) else $error("direction not applied");
   property p_hold; !wr_en |=> $stable(pin_out); endproperty
   a_hold: assert property (p_hold) else $error("latch changed without write");
   property p_mask; pin_out[0][7] == 1'b0 && pin_out[9][7:1] == 7'h00 && pin_out[10][7:2] == 6'h00; endproperty
   a_mask: assert property (p_mask) else $error("unimplemented latch bit set");
   property p_idle; !rd_en |=> rd_data == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data outside read slot");
   c_wr: cover property (wr_en && addr == 16'hff01);
   c_rd: cover property (rd_en && addr == 16'hff01 ##1 rd_data != 8'h00);
   c_bit: cover property (s_bit_wr);
endmodule
bind port_data_registers port_data_properties #(.NUM_PORTS(NUM_PORTS)) chk_u (.clk(clk), .sys_rst(sys_rst),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// File: verif/cpu_model.sv
// CPU side bus master issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module cpu_model
(
   input wire logic clk,
   output var logic [15:0] addr,
   output var logic [7:0] wr_data,
   output var logic wr_en,
   output var logic rd_en,
   input wire logic [7:0] rd_data
);
   initial
   begin
      addr = 16'h0000;
      wr_data = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
   end
   // Returns just after the strobe edge so callers see settled results
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking testbench for the port data register block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk;
   logic sys_rst;
   logic [15:0] addr;
   logic [7:0] wr_data;
   logic wr_en;
   logic rd_en;
   logic [7:0] rd_data;
   logic [7:0] rdv;
   logic [port_data_pkg::NUM_PORTS-1:0][7:0] pin_in;
   logic [port_data_pkg::NUM_PORTS-1:0][7:0] pin_out;
   logic [port_data_pkg::NUM_PORTS-1:0][7:0] pin_oe;
   int mismatches = 0;
   int checked = 0;
   cpu_model cpu_u (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
   port_data_registers dut_u (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task summarize;
      if (mismatches == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task t_reset;
      for (int i = 0; i < port_data_pkg::NUM_PORTS; i++)
         chk(pin_out[i], 8'h00);
      chk(pin_oe[1], 8'h00);
   endtask
   task t_output;
      cpu_u.wr(16'hff21, 8'h00);
      cpu_u.wr(16'hff01, 8'h5a);
      chk(pin_out[1], 8'h5a);
      chk(pin_oe[1], 8'hff);
      cpu_u.rd(16'hff01, rdv);
      chk(rdv, 8'h5a);
   endtask
   task t_input;
      cpu_u.wr(16'hff21, 8'hff);
      chk(pin_oe[1], 8'h00);
      cpu_u.rd(16'hff21, rdv);
      chk(rdv, 8'hff);
      cpu_u.rd(16'hff01, rdv);
      chk(rdv, 8'ha5);
      chk(pin_out[1], 8'h5a);
   endtask
   // Port 1, bit 7 then bit 1 through the single-bit window
   task t_bit;
      cpu_u.wr(16'hf80f, 8'h01);
      chk(pin_out[1], 8'hda);
      cpu_u.wr(16'hf809, 8'hfe);
      chk(pin_out[1], 8'hd8);
      cpu_u.rd(16'hf80f, rdv);
      chk(rdv, 8'h01);
   endtask
   // Port 0 bit 7 has no pin, through the byte map and the single-bit window
   task t_mask;
      cpu_u.wr(16'hff00, 8'hff);
      chk(pin_out[0], 8'h7f);
      cpu_u.wr(16'hf807, 8'h01);
      chk(pin_out[0], 8'h7f);
      cpu_u.wr(16'hff0d, 8'hff);
      chk(pin_out[9], 8'h01);
      chk(pin_oe[9], 8'h01);
      cpu_u.rd(16'hff10, rdv);
      chk(rdv, 8'h00);
   endtask
   // Port 12 in output mode, then main and sub clock pins taken by the oscillators
   task t_clk;
      cpu_u.wr(16'hff2c, 8'h00);
      cpu_u.wr(16'hff0c, 8'h1f);
      cpu_u.wr(16'hff40, 8'h01);
      cpu_u.rd(16'hff0c, rdv);
      chk(rdv, 8'h19);
      chk(pin_oe[8], 8'h19);
      cpu_u.wr(16'hff40, 8'h02);
      cpu_u.rd(16'hff0c, rdv);
      chk(rdv, 8'h07);
      chk(pin_oe[8], 8'h07);
      cpu_u.wr(16'hff40, 8'h03);
      cpu_u.rd(16'hff40, rdv);
      chk(rdv, 8'h03);
      cpu_u.rd(16'hff0c, rdv);
      chk(rdv, 8'h01);
      chk(pin_out[8], 8'h1f);
   endtask
   // Reset in mid-run must clear latches left set by the earlier scenarios
   task t_midreset;
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      for (int i = 0; i < port_data_pkg::NUM_PORTS; i++)
         chk(pin_out[i], 8'h00);
      chk(pin_oe[8], 8'h00);
      cpu_u.rd(16'hff40, rdv);
      chk(rdv, 8'h00);
   endtask
   initial
   begin
      pin_in = {port_data_pkg::NUM_PORTS{8'ha5}};
      sys_rst = 1'b1;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_output();
      t_input();
      t_bit();
      t_mask();
      t_clk();
      t_midreset();
      summarize();
   end
   // Whole run needs well under a thousand cycles
   initial
   begin
      #20000;
      mismatches++;
      summarize();
   end
endmodule
`default_nettype wire
